// ==== verilog/rlp_pkg.sv ====
// Purpose: Shared constants and types of the ring link protection block
// Assumes: 125 MHz station clock, 32-bit Avalon-MM register port
// Notes:   Byte offsets; every register is one aligned word

package rlp_pkg;

	// Request hierarchy, lowest first so that compares give priority
	typedef enum logic [2:0] {
		LVL_IDLE,
		LVL_WAIT_TO_RESTORE,
		LVL_SIGNAL_DEGRADE,
		LVL_SIGNAL_FAIL,
		LVL_MANUAL_SWITCH,
		LVL_FORCED_SWITCH
	} rlp_level_t;

	// Protection states of one receive link
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SWITCH,
		ST_FAILED,
		ST_WRAPPED_IDLE_WAIT,
		ST_WAIT_TO_RESTORE
	} rlp_state_t;

	// Sender of a received protection message
	typedef enum logic [1:0] {
		SRC_NEIGHBOR,
		SRC_OTHER,
		SRC_NEW_NEIGHBOR
	} rlp_src_t;

	////////////////////////////////////////////////////////////////////////
	// Register map
	localparam logic [4:0] REG_CTRL     = 5'h00;
	localparam logic [4:0] REG_STATUS   = 5'h04;
	localparam logic [4:0] REG_IRQ_STAT = 5'h08;
	localparam logic [4:0] REG_IRQ_CLR  = 5'h0c;
	localparam logic [4:0] REG_IRQ_EN   = 5'h10;

	// Field positions
	localparam int CTRL_STEER   = 0;
	localparam int STAT_STATE   = 0;
	localparam int STAT_PROT    = 3;
	localparam int STAT_WRAP    = 6;
	localparam int STAT_QUEUED  = 7;
	localparam int STAT_EXPIRED = 10;
	localparam int IRQ_STATE    = 0;
	localparam int IRQ_WRAP     = 1;
	localparam int IRQ_W        = 2;

	// Reset values
	localparam logic              STEER_RST  = 1'b0;
	localparam logic [IRQ_W-1:0]  IRQ_EN_RST = 2'h0;

	// Timing
	localparam int CLK_MHZ         = 125;
	localparam int WTR_TIME_US     = 10000;
	localparam int WTR_CYCLES_DFLT = WTR_TIME_US * CLK_MHZ;

endpackage : rlp_pkg

// ==== verilog/rlp_link_fsm.sv ====
// Purpose: Protection state machine for one receive link of a ring station
// Assumes: All event inputs come from logic on mclk, one-cycle pulses
// Notes:   Registers over Avalon-MM; every access answers on its second edge

`timescale 1ns/1ps

module rlp_link_fsm #(
	parameter int WTR_CYCLES = rlp_pkg::WTR_CYCLES_DFLT
) (
	input  wire logic               mclk,
	input  wire logic               nrst,
	input  wire logic [4:0]         avs_address,
	input  wire logic               avs_read,
	input  wire logic               avs_write,
	input  wire logic [31:0]        avs_writedata,
	output logic [31:0]             avs_readdata,
	output logic                    avs_waitrequest,
	input  wire logic               loc_req_valid,
	input  wire rlp_pkg::rlp_level_t loc_req_level,
	input  wire logic               loc_req_granted,
	input  wire logic               loc_fail_valid,
	input  wire rlp_pkg::rlp_level_t loc_fail_level,
	input  wire logic               loc_fail_wraps,
	input  wire logic               loc_fail_clear,
	input  wire logic               other_preempts,
	input  wire logic               rx_valid,
	input  wire rlp_pkg::rlp_level_t rx_level,
	input  wire rlp_pkg::rlp_src_t  rx_src,
	input  wire logic               rx_wrapped,
	input  wire logic               rx_short,
	input  wire logic               rx_preempts,
	output logic                    tx_valid,
	output rlp_pkg::rlp_level_t     tx_level,
	output logic                    tx_wrapped,
	output logic                    wrap_status,
	output rlp_pkg::rlp_level_t     side_link_prot_state,
	output logic                    irq
);

	rlp_pkg::rlp_state_t  state_ff;
	rlp_pkg::rlp_state_t  nxt_state;
	rlp_pkg::rlp_level_t  prot_ff;
	rlp_pkg::rlp_level_t  nxt_prot;
	rlp_pkg::rlp_level_t  queued_ff;
	rlp_pkg::rlp_level_t  nxt_queued;
	rlp_pkg::rlp_level_t  tx_level_ff;
	logic                 wrap_ff;
	logic                 nxt_wrap;
	logic                 fire;
	logic                 tx_valid_ff;
	logic                 tx_wrapped_ff;
	logic                 steer_ff;
	logic [31:0]          wtr_cnt_ff;
	logic                 wtr_done;
	logic [rlp_pkg::IRQ_W-1:0] irq_stat_ff;
	logic [rlp_pkg::IRQ_W-1:0] nxt_irq_stat;
	logic [rlp_pkg::IRQ_W-1:0] irq_en_ff;
	logic                 irq_ff;
	logic                 wait_ff;
	logic [31:0]          rdata_ff;
	logic                 wrap_ok;
	logic                 nbr_rx;
	logic                 pre_any;
	logic                 req_ok;
	logic                 bus_wr;

	// Wrap actions exist only on wrapping rings
	assign wrap_ok  = !steer_ff;
	assign nbr_rx   = rx_valid && (rx_src == rlp_pkg::SRC_NEIGHBOR);
	assign pre_any  = other_preempts || (rx_valid && rx_src == rlp_pkg::SRC_OTHER && rx_preempts);
	assign req_ok   = loc_req_valid && loc_req_granted;
	assign wtr_done = (state_ff == rlp_pkg::ST_WAIT_TO_RESTORE) && (wtr_cnt_ff == 32'h0);

	////////////////////////////////////////////////////////////////////////
	// Next-state decision; earlier branches win within a state
	always_comb
	begin
		nxt_state  = state_ff;
		nxt_prot   = prot_ff;
		nxt_wrap   = wrap_ff;
		nxt_queued = queued_ff;
		fire       = 1'b0;
		case (state_ff)
			rlp_pkg::ST_IDLE:
			begin
				if (req_ok)
				begin
					nxt_state = rlp_pkg::ST_SWITCH;
					nxt_prot  = loc_req_level;
					nxt_wrap  = wrap_ok;
					fire      = 1'b1;
				end
				else if (loc_fail_valid)
				begin
					nxt_state = rlp_pkg::ST_FAILED;
					nxt_prot  = loc_fail_level;
					nxt_wrap  = wrap_ok && loc_fail_wraps;
					fire      = 1'b1;
				end
				else if (wrap_ok && nbr_rx && rx_short && rx_wrapped && rx_level != rlp_pkg::LVL_IDLE)
				begin
					nxt_state = rlp_pkg::ST_WRAPPED_IDLE_WAIT;
					nxt_wrap  = 1'b1;
					fire      = 1'b1;
				end
			end
			rlp_pkg::ST_SWITCH:
			begin
				// Preemption drops the switch and its queued request
				if (pre_any)
				begin
					nxt_state  = rlp_pkg::ST_IDLE;
					nxt_prot   = rlp_pkg::LVL_IDLE;
					nxt_queued = rlp_pkg::LVL_IDLE;
					nxt_wrap   = 1'b0;
					fire       = 1'b1;
				end
			end
			rlp_pkg::ST_FAILED:
			begin
				if (loc_fail_clear)
				begin
					nxt_state = rlp_pkg::ST_WAIT_TO_RESTORE;
					nxt_prot  = rlp_pkg::LVL_WAIT_TO_RESTORE;
					fire      = 1'b1;
				end
				else if (req_ok)
				begin
					nxt_state  = rlp_pkg::ST_SWITCH;
					nxt_queued = prot_ff;
					nxt_prot   = loc_req_level;
					nxt_wrap   = wrap_ok;
					fire       = 1'b1;
				end
				else if (wrap_ok && nbr_rx && rx_short && rx_wrapped &&
					rx_level == rlp_pkg::LVL_FORCED_SWITCH && prot_ff != rlp_pkg::LVL_SIGNAL_FAIL)
				begin
					nxt_wrap = 1'b1;
					fire     = 1'b1;
				end
				else if (wrap_ok && pre_any)
				begin
					nxt_wrap = 1'b0;
					fire     = 1'b1;
				end
			end
			rlp_pkg::ST_WRAPPED_IDLE_WAIT:
			begin
				if (req_ok)
				begin
					nxt_state = rlp_pkg::ST_SWITCH;
					nxt_prot  = loc_req_level;
					nxt_wrap  = wrap_ok;
					fire      = 1'b1;
				end
				else if (loc_fail_valid)
				begin
					nxt_state = rlp_pkg::ST_FAILED;
					nxt_prot  = loc_fail_level;
					nxt_wrap  = wrap_ok && loc_fail_wraps;
					fire      = 1'b1;
				end
				else if (nbr_rx && rx_level == rlp_pkg::LVL_IDLE && !rx_wrapped)
				begin
					nxt_state = rlp_pkg::ST_IDLE;
					nxt_wrap  = 1'b0;
					fire      = 1'b1;
				end
			end
			rlp_pkg::ST_WAIT_TO_RESTORE:
			begin
				if (req_ok)
				begin
					nxt_state = rlp_pkg::ST_SWITCH;
					nxt_prot  = loc_req_level;
					nxt_wrap  = wrap_ok;
					fire      = 1'b1;
				end
				else if (loc_fail_valid && loc_fail_wraps)
				begin
					nxt_state = rlp_pkg::ST_FAILED;
					nxt_prot  = loc_fail_level;
					nxt_wrap  = wrap_ok;
					fire      = 1'b1;
				end
				else if (pre_any)
				begin
					nxt_state = rlp_pkg::ST_IDLE;
					nxt_prot  = rlp_pkg::LVL_IDLE;
					nxt_wrap  = 1'b0;
					fire      = 1'b1;
				end
				else if (rx_valid && rx_src == rlp_pkg::SRC_NEW_NEIGHBOR && rx_short &&
					!rx_wrapped && rx_level == rlp_pkg::LVL_IDLE)
				begin
					nxt_state = rlp_pkg::ST_IDLE;
					nxt_prot  = rlp_pkg::LVL_IDLE;
					nxt_wrap  = 1'b0;
					fire      = 1'b1;
				end
				else if (wrap_ok && nbr_rx && rx_wrapped && rx_level == rlp_pkg::LVL_IDLE && wtr_done)
				begin
					nxt_state = rlp_pkg::ST_IDLE;
					nxt_prot  = rlp_pkg::LVL_IDLE;
					nxt_wrap  = 1'b0;
					fire      = 1'b1;
				end
				else if (wrap_ok && nbr_rx && rx_wrapped && rx_level > rlp_pkg::LVL_WAIT_TO_RESTORE)
				begin
					nxt_state = rlp_pkg::ST_WRAPPED_IDLE_WAIT;
					nxt_prot  = rlp_pkg::LVL_IDLE;
					nxt_wrap  = 1'b1;
					fire      = 1'b1;
				end
				else if (steer_ff && wtr_done)
				begin
					nxt_state = rlp_pkg::ST_IDLE;
					nxt_prot  = rlp_pkg::LVL_IDLE;
					fire      = 1'b1;
				end
			end
			default:
			begin
				nxt_state = rlp_pkg::ST_IDLE;
			end
		endcase
	end

	// Protection state registers; unchanged when nothing fires
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			state_ff  <= rlp_pkg::ST_IDLE;
			prot_ff   <= rlp_pkg::LVL_IDLE;
			queued_ff <= rlp_pkg::LVL_IDLE;
			wrap_ff   <= 1'b0;
		end
		else
		begin
			state_ff  <= nxt_state;
			prot_ff   <= nxt_prot;
			queued_ff <= nxt_queued;
			wrap_ff   <= nxt_wrap;
		end
	end

	// One message per firing, carrying the resulting state
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			tx_valid_ff   <= 1'b0;
			tx_level_ff   <= rlp_pkg::LVL_IDLE;
			tx_wrapped_ff <= 1'b0;
		end
		else
		begin
			tx_valid_ff <= fire;
			if (fire)
			begin
				tx_level_ff   <= nxt_prot;
				tx_wrapped_ff <= nxt_wrap;
			end
		end
	end

	// Restore timer reloads on every entry, so a re-entry restarts the wait
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			wtr_cnt_ff <= 32'h0;
		else if (nxt_state == rlp_pkg::ST_WAIT_TO_RESTORE && state_ff != rlp_pkg::ST_WAIT_TO_RESTORE)
			wtr_cnt_ff <= 32'(WTR_CYCLES - 1);
		else if (wtr_cnt_ff != 32'h0)
			wtr_cnt_ff <= wtr_cnt_ff - 32'h1;
	end

	////////////////////////////////////////////////////////////////////////
	// Avalon slave: wait one cycle, answer on the second edge
	assign bus_wr = avs_write && !wait_ff;

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			wait_ff  <= 1'b1;
			rdata_ff <= 32'h0;
		end
		else
		begin
			wait_ff <= !((avs_read || avs_write) && wait_ff);
			if (avs_read && wait_ff)
			begin
				if (avs_address == rlp_pkg::REG_CTRL)
					rdata_ff <= {31'h0, steer_ff};
				else if (avs_address == rlp_pkg::REG_STATUS)
					rdata_ff <= {21'h0, wtr_done, queued_ff, wrap_ff, prot_ff, state_ff};
				else if (avs_address == rlp_pkg::REG_IRQ_STAT)
					rdata_ff <= {30'h0, irq_stat_ff};
				else if (avs_address == rlp_pkg::REG_IRQ_EN)
					rdata_ff <= {30'h0, irq_en_ff};
				else
					rdata_ff <= 32'h0;
			end
		end
	end

	// Control registers; writes to other offsets are dropped
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			steer_ff  <= rlp_pkg::STEER_RST;
			irq_en_ff <= rlp_pkg::IRQ_EN_RST;
		end
		else if (bus_wr && avs_address == rlp_pkg::REG_CTRL)
			steer_ff <= avs_writedata[rlp_pkg::CTRL_STEER];
		else if (bus_wr && avs_address == rlp_pkg::REG_IRQ_EN)
			irq_en_ff <= avs_writedata[rlp_pkg::IRQ_W-1:0];
	end

	// Sticky events: a set in the clearing cycle survives
	always_comb
	begin
		nxt_irq_stat = irq_stat_ff;
		if (bus_wr && avs_address == rlp_pkg::REG_IRQ_CLR)
			nxt_irq_stat = irq_stat_ff & ~avs_writedata[rlp_pkg::IRQ_W-1:0];
		if (fire && nxt_state != state_ff)
			nxt_irq_stat[rlp_pkg::IRQ_STATE] = 1'b1;
		if (fire && nxt_wrap != wrap_ff)
			nxt_irq_stat[rlp_pkg::IRQ_WRAP] = 1'b1;
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			irq_stat_ff <= 2'h0;
			irq_ff      <= 1'b0;
		end
		else
		begin
			irq_stat_ff <= nxt_irq_stat;
			irq_ff      <= |(nxt_irq_stat & irq_en_ff);
		end
	end

	// Outputs straight from flops
	assign avs_readdata         = rdata_ff;
	assign avs_waitrequest      = wait_ff;
	assign tx_valid             = tx_valid_ff;
	assign tx_level             = tx_level_ff;
	assign tx_wrapped           = tx_wrapped_ff;
	assign wrap_status          = wrap_ff;
	assign side_link_prot_state = prot_ff;
	assign irq                  = irq_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence s_state_moved;
		state_ff != $past(state_ff);
	endsequence

	sequence s_quiet;
		!(loc_req_valid || loc_fail_valid || loc_fail_clear || other_preempts || rx_valid) && !wtr_done;
	endsequence

	a_preempt_clears_switch: assert property ((state_ff == rlp_pkg::ST_SWITCH && other_preempts) |=>
		(state_ff == rlp_pkg::ST_IDLE && !wrap_ff && tx_valid_ff)) else $error("switch not cleared by preemption");

	a_clear_reports_wtr: assert property ((state_ff == rlp_pkg::ST_FAILED && loc_fail_clear) |=>
		(tx_valid_ff && tx_level_ff == rlp_pkg::LVL_WAIT_TO_RESTORE)) else $error("restore wait not reported");

	a_request_queues_fail: assert property ((state_ff == rlp_pkg::ST_FAILED && !loc_fail_clear && req_ok) |=>
		(queued_ff == $past(prot_ff) && wrap_ff == $past(wrap_ok))) else $error("failure not queued");

	a_remote_unwraps: assert property ((state_ff == rlp_pkg::ST_WAIT_TO_RESTORE && other_preempts &&
		!loc_req_valid && !loc_fail_valid) |=> (state_ff == rlp_pkg::ST_IDLE && !wrap_ff)) else $error("restore not cleared");

	a_steer_expiry_idle: assert property ((steer_ff && wtr_done && !loc_req_valid && !loc_fail_valid &&
		!other_preempts && !rx_valid) |=> (state_ff == rlp_pkg::ST_IDLE && tx_valid_ff)) else $error("expiry ignored");

	a_steer_no_wrap: assert property ((steer_ff && !wrap_ff) |=> !wrap_ff) else $error("wrap set in steering");

	a_change_sends_msg: assert property (s_state_moved |-> (tx_valid_ff && tx_level_ff == prot_ff))
		else $error("state change without message");

	a_quiet_holds_state: assert property (s_quiet |=> ($stable(state_ff) && !tx_valid_ff))
		else $error("state moved without cause");

	a_wait_idle_unwraps: assert property ((state_ff == rlp_pkg::ST_WRAPPED_IDLE_WAIT && nbr_rx && !rx_wrapped &&
		rx_level == rlp_pkg::LVL_IDLE && !loc_req_valid && !loc_fail_valid) |=> (!wrap_ff ##1 !tx_valid_ff))
		else $error("wrap kept after neighbour idle");

	a_bus_answers: assert property (((avs_read || avs_write) && wait_ff) |=> !wait_ff ##1 wait_ff)
		else $error("bus answer timing");

endmodule : rlp_link_fsm

// ==== verification/rlp_peer.sv ====
// Purpose: Peer stations that send and collect protection messages
// Assumes: Same clock as the link block
// Notes:   Released message level and flags show inverted values; source is kept
`timescale 1ns/1ps
module rlp_peer (
	input  wire logic         mclk,
	output logic              rx_valid,
	output rlp_pkg::rlp_level_t rx_level,
	output rlp_pkg::rlp_src_t rx_src,
	output logic              rx_wrapped,
	output logic              rx_short,
	output logic              rx_preempts,
	input  wire logic         tx_valid,
	input  wire rlp_pkg::rlp_level_t tx_level,
	input  wire logic         tx_wrapped
);
	int                  n_msg = 0;
	rlp_pkg::rlp_level_t last_lvl = rlp_pkg::LVL_IDLE;
	logic                last_wrap = 1'b0;
	initial
	begin
		{rx_valid, rx_wrapped, rx_short, rx_preempts} = 4'h0;
		rx_level = rlp_pkg::LVL_IDLE;
		rx_src = rlp_pkg::SRC_NEIGHBOR;
	end
	// Collect every message sent toward us; counts kept for the bench
	always @(posedge mclk)
		if (tx_valid === 1'b1)
		begin
			n_msg <= n_msg + 1;
			last_lvl <= tx_level;
			last_wrap <= tx_wrapped;
		end
	task send(input rlp_pkg::rlp_level_t l, input rlp_pkg::rlp_src_t s, input logic w, input logic sh,
		input logic p);
		@(posedge mclk);
		rx_valid <= 1'b1;
		rx_level <= l;
		rx_src <= s;
		{rx_wrapped, rx_short, rx_preempts} <= {w, sh, p};
		// One-cycle message; stale level and flags are inverted so nothing lives on them
		@(posedge mclk);
		rx_valid <= 1'b0;
		rx_level <= rlp_pkg::rlp_level_t'(~l);
		{rx_wrapped, rx_short, rx_preempts} <= ~{w, sh, p};
		#1;
	endtask : send
endmodule : rlp_peer

// ==== verification/tb_ring_link_protection_fsm.sv ====
// Purpose: Self-checking bench of the link protection machine
// Assumes: Restore time shortened to 8 cycles
// Notes:   Each scenario starts and ends in idle
`timescale 1ns/1ps
module tb_ring_link_protection_fsm;
	logic                mclk = 1'b0;
	logic                nrst = 1'b0;
	logic [4:0]          avs_address = 5'h00;
	logic                avs_read = 1'b0;
	logic                avs_write = 1'b0;
	logic [31:0]         avs_writedata = 32'h0;
	logic [31:0]         avs_readdata;
	logic                avs_waitrequest;
	logic [4:0]          ev_sel = 5'h00;
	rlp_pkg::rlp_level_t lvl = rlp_pkg::LVL_IDLE;
	logic                fail_wraps = 1'b0;
	logic                rx_valid;
	rlp_pkg::rlp_level_t rx_level;
	rlp_pkg::rlp_src_t   rx_src;
	logic                rx_wrapped;
	logic                rx_short;
	logic                rx_preempts;
	logic                tx_valid;
	rlp_pkg::rlp_level_t tx_level;
	logic                tx_wrapped;
	logic                wrap_status;
	rlp_pkg::rlp_level_t side_link_prot_state;
	logic                irq;
	logic [31:0]         q;
	int                  mismatches = 0;
	int                  checks_done = 0;
	int                  cycles = 0;

	always #4 mclk = ~mclk;

	rlp_link_fsm #(.WTR_CYCLES(8)) i_dut (
		.mclk(mclk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .loc_req_valid(ev_sel[3]), .loc_req_level(lvl),
		.loc_req_granted(ev_sel[4]), .loc_fail_valid(ev_sel[2]), .loc_fail_level(lvl),
		.loc_fail_wraps(fail_wraps), .loc_fail_clear(ev_sel[1]), .other_preempts(ev_sel[0]),
		.rx_valid(rx_valid), .rx_level(rx_level), .rx_src(rx_src), .rx_wrapped(rx_wrapped),
		.rx_short(rx_short), .rx_preempts(rx_preempts), .tx_valid(tx_valid), .tx_level(tx_level),
		.tx_wrapped(tx_wrapped), .wrap_status(wrap_status),
		.side_link_prot_state(side_link_prot_state), .irq(irq)
	);

	rlp_peer i_peer (
		.mclk(mclk), .rx_valid(rx_valid), .rx_level(rx_level), .rx_src(rx_src),
		.rx_wrapped(rx_wrapped), .rx_short(rx_short), .rx_preempts(rx_preempts),
		.tx_valid(tx_valid), .tx_level(tx_level), .tx_wrapped(tx_wrapped)
	);

	////////////////////////////////////////////////////////////////////////
	task give_verdict;
		if (mismatches == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict

	// Hang guard; scenarios need well under a thousand cycles
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 4000)
		begin
			mismatches = mismatches + 1;
			give_verdict();
		end
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp)
		begin
			mismatches = mismatches + 1;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Link level, wrap and message of the cycle after an event
	task look(input logic [2:0] p, input logic w, input logic v);
		chk(side_link_prot_state, p);
		chk(wrap_status, w);
		chk(tx_valid, v);
		if (v)
		begin
			chk(tx_level, p);
			chk(tx_wrapped, w);
		end
	endtask : look

	// Event pulse {granted, request, failure, clear, preempt}, one cycle
	task ev(input logic [4:0] sel, input rlp_pkg::rlp_level_t l, input logic w);
		@(posedge mclk);
		ev_sel <= sel;
		lvl <= l;
		fail_wraps <= w;
		@(posedge mclk);
		ev_sel <= 5'h00;
		#1;
	endtask : ev

	// Request held until waitrequest is sampled low; data taken there
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge mclk);
		avs_write <= wr;
		avs_read <= !wr;
		avs_address <= a;
		avs_writedata <= d;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0)
			@(posedge mclk);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		#1;
	endtask : bus

	////////////////////////////////////////////////////////////////////////
	task t_switch;
		ev(5'h08, rlp_pkg::LVL_FORCED_SWITCH, 1'b0);
		look(3'h0, 1'b0, 1'b0);
		ev(5'h18, rlp_pkg::LVL_FORCED_SWITCH, 1'b0);
		look(3'h5, 1'b1, 1'b1);
		ev(5'h01, rlp_pkg::LVL_IDLE, 1'b0);
		look(3'h0, 1'b0, 1'b1);
	endtask : t_switch

	task t_fail;
		ev(5'h04, rlp_pkg::LVL_SIGNAL_DEGRADE, 1'b0);
		look(3'h2, 1'b0, 1'b1);
		i_peer.send(rlp_pkg::LVL_FORCED_SWITCH, rlp_pkg::SRC_NEIGHBOR, 1'b1, 1'b1, 1'b0);
		look(3'h2, 1'b1, 1'b1);
		i_peer.send(rlp_pkg::LVL_SIGNAL_FAIL, rlp_pkg::SRC_OTHER, 1'b0, 1'b0, 1'b1);
		look(3'h2, 1'b0, 1'b1);
		ev(5'h18, rlp_pkg::LVL_MANUAL_SWITCH, 1'b0);
		look(3'h4, 1'b1, 1'b1);
		bus(1'b0, rlp_pkg::REG_STATUS, 32'h0);
		chk(q, 32'h0000_0161);
		ev(5'h01, rlp_pkg::LVL_IDLE, 1'b0);
		look(3'h0, 1'b0, 1'b1);
	endtask : t_fail

	task t_wfn;
		i_peer.send(rlp_pkg::LVL_SIGNAL_FAIL, rlp_pkg::SRC_NEIGHBOR, 1'b1, 1'b1, 1'b0);
		look(3'h0, 1'b1, 1'b1);
		ev(5'h04, rlp_pkg::LVL_SIGNAL_FAIL, 1'b0);
		look(3'h3, 1'b0, 1'b1);
		ev(5'h02, rlp_pkg::LVL_IDLE, 1'b0);
		look(3'h1, 1'b0, 1'b1);
		i_peer.send(rlp_pkg::LVL_SIGNAL_FAIL, rlp_pkg::SRC_NEIGHBOR, 1'b1, 1'b0, 1'b0);
		look(3'h0, 1'b1, 1'b1);
		i_peer.send(rlp_pkg::LVL_IDLE, rlp_pkg::SRC_NEIGHBOR, 1'b0, 1'b0, 1'b0);
		look(3'h0, 1'b0, 1'b1);
	endtask : t_wfn

	task t_wtr;
		ev(5'h04, rlp_pkg::LVL_SIGNAL_FAIL, 1'b1);
		look(3'h3, 1'b1, 1'b1);
		ev(5'h02, rlp_pkg::LVL_IDLE, 1'b0);
		look(3'h1, 1'b1, 1'b1);
		i_peer.send(rlp_pkg::LVL_IDLE, rlp_pkg::SRC_NEIGHBOR, 1'b1, 1'b0, 1'b0);
		look(3'h1, 1'b1, 1'b0);
		repeat (8) @(posedge mclk);
		i_peer.send(rlp_pkg::LVL_IDLE, rlp_pkg::SRC_NEIGHBOR, 1'b1, 1'b0, 1'b0);
		look(3'h0, 1'b0, 1'b1);
		ev(5'h04, rlp_pkg::LVL_SIGNAL_FAIL, 1'b1);
		ev(5'h02, rlp_pkg::LVL_IDLE, 1'b0);
		i_peer.send(rlp_pkg::LVL_IDLE, rlp_pkg::SRC_NEW_NEIGHBOR, 1'b0, 1'b1, 1'b0);
		look(3'h0, 1'b0, 1'b1);
		ev(5'h04, rlp_pkg::LVL_SIGNAL_FAIL, 1'b1);
		ev(5'h02, rlp_pkg::LVL_IDLE, 1'b0);
		ev(5'h04, rlp_pkg::LVL_SIGNAL_DEGRADE, 1'b1);
		look(3'h2, 1'b1, 1'b1);
		ev(5'h02, rlp_pkg::LVL_IDLE, 1'b0);
		ev(5'h01, rlp_pkg::LVL_IDLE, 1'b0);
		look(3'h0, 1'b0, 1'b1);
	endtask : t_wtr

	task t_steer;
		bus(1'b1, rlp_pkg::REG_CTRL, 32'h1);
		bus(1'b1, rlp_pkg::REG_IRQ_EN, 32'h3);
		bus(1'b1, rlp_pkg::REG_IRQ_CLR, 32'h3);
		ev(5'h04, rlp_pkg::LVL_SIGNAL_FAIL, 1'b1);
		look(3'h3, 1'b0, 1'b1);
		chk(irq, 1'b1);
		bus(1'b0, rlp_pkg::REG_IRQ_STAT, 32'h0);
		chk(q, 32'h1);
		ev(5'h02, rlp_pkg::LVL_IDLE, 1'b0);
		repeat (12) @(posedge mclk);
		#1;
		look(3'h0, 1'b0, 1'b0);
		chk(i_peer.last_lvl, rlp_pkg::LVL_IDLE);
		bus(1'b1, rlp_pkg::REG_IRQ_CLR, 32'h3);
		chk(irq, 1'b0);
	endtask : t_steer

	// Reset in mid-run returns to wrapping mode and idle
	task t_reset;
		@(posedge mclk);
		nrst <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		look(3'h0, 1'b0, 1'b0);
		chk(avs_waitrequest, 1'b1);
		@(posedge mclk);
		nrst <= 1'b1;
		bus(1'b0, rlp_pkg::REG_CTRL, 32'h0);
		chk(q, 32'h0);
	endtask : t_reset

	initial
	begin
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		#1;
		look(3'h0, 1'b0, 1'b0);
		bus(1'b0, rlp_pkg::REG_STATUS, 32'h0);
		chk(q, 32'h0);
		t_switch();
		t_fail();
		t_wfn();
		t_wtr();
		t_steer();
		t_reset();
		give_verdict();
	end
endmodule : tb_ring_link_protection_fsm
